//--- hw/hpp_host_port.sv
/*
 * Host processor port: parallel slave in two strobe styles or serial slave
 * with strapped clock mode and bit order, feeding a one-byte register
 * request port; open-drain interrupt pin.
 * Assumes all pins are asynchronous to mclk, the serial clock is at least
 * eight times slower than mclk, and reg_rdata is valid the cycle after
 * reg_rd.
 */
// How it works
// - Strobe style low: separate read/write strobes
// - Strobe style high: direction select plus data strobe
// - One byte per access on data bus
// - Thirteen dedicated address lines select register
// - No multiplexed address/data mode
// - Read or write strobe marks direction, latches
// - Direction level plus data strobe latch
// - Interrupt pin low while unmasked condition present
// - Serial select high gives serial slave
// - Data bits 7,6 strap polarity and phase
// - Data bit 5 straps serial bit order
// - Direction first, burst last in control word
// - Control bytes then one data byte
// - Burst: address increments, no more control
// - No burst: control bytes follow data
// - Select release ends burst; control next
// - Select may stay or drop between accesses
`timescale 1ns/1ps
`default_nettype none
`include "hpp_map.svh"

module hpp_host_port #(
    parameter int ADDR_W = `HPP_ADDR_BITS
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic serial_port_select,
    input wire logic bus_style_select,
    input wire logic chip_select_n,
    input wire hpp_pkg::hpp_addr_t address,
    input wire hpp_pkg::hpp_data_t data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic read_write_select,
    input wire logic data_strobe_n,
    input wire logic serial_clock,
    input wire logic serial_mosi,
    output logic serial_miso,
    output logic serial_miso_oe,
    input wire logic irq_pending,
    output logic interrupt_request_n,
    output logic interrupt_request_oe,
    output logic [12:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire hpp_pkg::hpp_data_t reg_rdata
);
    import hpp_pkg::*;

    if (ADDR_W != `HPP_ADDR_BITS) begin : g_chk
        $error("hpp_host_port: address width must be 13");
    end

    function automatic logic [15:0] hpp_rev16(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction : hpp_rev16

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    hpp_pins_s pin_raw, meta_q, sync_q;

    always_comb begin
        pin_raw = '{serial_port_select, bus_style_select, chip_select_n,
                    read_strobe_n, write_strobe_n, data_strobe_n,
                    read_write_select, serial_clock, serial_mosi,
                    address, data_in};
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ds_n: 1'b1, default: '0};
            sync_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ds_n: 1'b1, default: '0};
        end else begin
            meta_q <= pin_raw;
            sync_q <= meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port state
    logic sel_q, sel_d, sclk_q, sclk_d;
    logic cpol_q, cpol_d, cpha_q, cpha_d, swap_q, swap_d;
    logic act_q, act_d, prd_q, prd_d;
    hpp_data_t pwd_q, pwd_d;
    hpp_state_e st_q, st_d;
    logic [3:0] bcnt_q, bcnt_d;
    logic [15:0] sh_q, sh_d;
    logic rw_q, rw_d, burst_q, burst_d;
    hpp_addr_t sa_q, sa_d, ra_q, ra_d;
    hpp_data_t rwd_q, rwd_d, tx_q, tx_d, dout_q, dout_d;
    logic wr_q, wr_d, rd_q, rd_d, rdw_q, rdw_d;
    logic doe_q, doe_d, miso_q, miso_d, moe_q, moe_d, ioe_q, ioe_d;

    logic csn_s, par_act, par_rd, par_start, par_end;
    logic sclk_rise, sclk_fall, samp, shft;
    logic [15:0] cw, mid_rev, db_rev, tx_rev;
    logic [13:0] mid;
    hpp_data_t db;

    always_comb begin
        csn_s = sync_q.cs_n;
        // Parallel access window and direction per strobe style
        par_act = !csn_s && (sync_q.bus_style ? !sync_q.ds_n
                                              : (!sync_q.rd_n || !sync_q.wr_n));
        par_rd = sync_q.bus_style ? sync_q.rw : !sync_q.rd_n;
        par_start = !sel_q && par_act && !act_q;
        par_end = !sel_q && act_q && !par_act;
        // Sample on leading edge when phase is 0, trailing when 1
        sclk_rise = sync_q.sclk && !sclk_q;
        sclk_fall = !sync_q.sclk && sclk_q;
        samp = (cpol_q ^ cpha_q) ? sclk_fall : sclk_rise;
        shft = (cpol_q ^ cpha_q) ? sclk_rise : sclk_fall;
        cw = {sh_q[14:0], sync_q.mosi};
        mid_rev = hpp_rev16({cw[14:1], 2'b00});
        db_rev = hpp_rev16({cw[7:0], 8'h00});
        tx_rev = hpp_rev16({reg_rdata, 8'h00});
        mid = swap_q ? mid_rev[13:0] : cw[14:1];
        db = swap_q ? db_rev[7:0] : cw[7:0];

        sel_d = sync_q.serial_sel;
        sclk_d = sync_q.sclk;
        cpol_d = cpol_q;
        cpha_d = cpha_q;
        swap_d = swap_q;
        act_d = !sel_q && par_act;
        prd_d = par_start ? par_rd : prd_q;
        pwd_d = par_act ? sync_q.data : pwd_q;
        st_d = st_q;
        bcnt_d = bcnt_q;
        sh_d = sh_q;
        rw_d = rw_q;
        burst_d = burst_q;
        sa_d = sa_q;
        ra_d = ra_q;
        rwd_d = rwd_q;
        tx_d = tx_q;
        miso_d = miso_q;
        wr_d = 1'b0;
        rd_d = 1'b0;
        rdw_d = rd_q;
        dout_d = (rdw_q && !sel_q) ? reg_rdata : dout_q;
        doe_d = !sel_q && par_act && par_rd;
        moe_d = sel_q && !csn_s;
        ioe_d = irq_pending;

        if (par_start) begin
            ra_d = sync_q.addr;
            rd_d = par_rd;
        end
        if (par_end && !prd_q) begin
            rwd_d = pwd_q;
            wr_d = 1'b1;
        end

        if (sel_q && rdw_q) begin
            tx_d = swap_q ? tx_rev[7:0] : reg_rdata;
        end
        if (!sel_q || csn_s) begin
            st_d = HPP_IDLE;
            bcnt_d = 4'h0;
            if (sel_q) begin
                cpol_d = sync_q.data[`HPP_STRAP_CPOL];
                cpha_d = sync_q.data[`HPP_STRAP_CPHA];
                swap_d = sync_q.data[`HPP_STRAP_SWAP];
            end
        end else begin
            if (st_q == HPP_IDLE) begin
                st_d = HPP_CTRL;
            end
            if (shft) begin
                miso_d = tx_q[7];
                tx_d = {tx_q[6:0], 1'b0};
            end
            if (samp) begin
                sh_d = cw;
                bcnt_d = bcnt_q + 4'h1;
                case (st_q)
                    HPP_IDLE, HPP_CTRL: begin
                        if (bcnt_q == `HPP_CTRL_LAST) begin
                            rw_d = cw[`HPP_CW_RW];
                            burst_d = cw[`HPP_CW_BURST];
                            sa_d = mid[12:0];
                            ra_d = mid[12:0];
                            rd_d = cw[`HPP_CW_RW];
                            bcnt_d = 4'h0;
                            st_d = HPP_DATA;
                        end
                    end
                    HPP_DATA: begin
                        if (bcnt_q == `HPP_DATA_LAST) begin
                            bcnt_d = 4'h0;
                            if (!rw_q) begin
                                ra_d = sa_q;
                                rwd_d = db;
                                wr_d = 1'b1;
                            end
                            if (burst_q) begin
                                sa_d = sa_q + 13'h0001;
                                if (rw_q) ra_d = sa_q + 13'h0001;
                                rd_d = rw_q;
                            end else begin
                                st_d = HPP_CTRL;
                            end
                        end
                    end
                    default: st_d = HPP_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sel_q <= 1'b0;
            sclk_q <= 1'b0;
            cpol_q <= 1'b0;
            cpha_q <= 1'b0;
            swap_q <= 1'b0;
            act_q <= 1'b0;
            prd_q <= 1'b0;
            pwd_q <= 8'h00;
            st_q <= HPP_IDLE;
            bcnt_q <= 4'h0;
            sh_q <= 16'h0000;
            rw_q <= 1'b0;
            burst_q <= 1'b0;
            sa_q <= 13'h0000;
            ra_q <= 13'h0000;
            rwd_q <= 8'h00;
            tx_q <= 8'h00;
            dout_q <= 8'h00;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            rdw_q <= 1'b0;
            doe_q <= 1'b0;
            miso_q <= 1'b0;
            moe_q <= 1'b0;
            ioe_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            sclk_q <= sclk_d;
            cpol_q <= cpol_d;
            cpha_q <= cpha_d;
            swap_q <= swap_d;
            act_q <= act_d;
            prd_q <= prd_d;
            pwd_q <= pwd_d;
            st_q <= st_d;
            bcnt_q <= bcnt_d;
            sh_q <= sh_d;
            rw_q <= rw_d;
            burst_q <= burst_d;
            sa_q <= sa_d;
            ra_q <= ra_d;
            rwd_q <= rwd_d;
            tx_q <= tx_d;
            dout_q <= dout_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            rdw_q <= rdw_d;
            doe_q <= doe_d;
            miso_q <= miso_d;
            moe_q <= moe_d;
            ioe_q <= ioe_d;
        end
    end

    assign data_out = dout_q;
    assign data_oe = doe_q;
    assign serial_miso = miso_q;
    assign serial_miso_oe = moe_q;
    assign interrupt_request_n = 1'b0;  // Open drain: only the enable moves
    assign interrupt_request_oe = ioe_q;
    assign reg_addr = ra_q;
    assign reg_wdata = rwd_q;
    assign reg_wr = wr_q;
    assign reg_rd = rd_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence ctrl_done;
        sel_q && !csn_s && st_q == HPP_CTRL && samp && bcnt_q == `HPP_CTRL_LAST;
    endsequence
    sequence data_done;
        sel_q && !csn_s && st_q == HPP_DATA && samp && bcnt_q == `HPP_DATA_LAST;
    endsequence

    AST_SEP_READ: assert property (par_start && !sync_q.bus_style && !sync_q.rd_n
        |=> reg_rd ##1 !reg_rd) else $error("separate strobe read not issued");
    AST_DS_READ: assert property (par_start && sync_q.bus_style && sync_q.rw
        |=> reg_rd && reg_addr == $past(sync_q.addr)) else $error("strobe read lost");
    AST_PAR_WRITE: assert property (par_end && !prd_q
        |=> reg_wr && reg_wdata == $past(pwd_q)) else $error("parallel write lost");
    AST_IGNORE_CS: assert property (!sel_q && csn_s |=> !reg_rd)
        else $error("access while deselected");
    AST_IRQ_PIN: assert property (##1 interrupt_request_oe == $past(irq_pending))
        else $error("interrupt pin does not follow condition");
    AST_SER_QUIET: assert property (sel_q |=> !data_oe)
        else $error("data bus driven in serial mode");
    AST_CW_FLAGS: assert property (ctrl_done |=> st_q == HPP_DATA
        && burst_q == $past(sync_q.mosi) && rw_q == $past(sh_q[14]))
        else $error("control word flags misplaced");
    AST_BURST_INC: assert property (data_done and burst_q
        |=> st_q == HPP_DATA && sa_q == $past(sa_q) + 13'h0001)
        else $error("burst address not incremented");
    AST_NO_BURST: assert property (data_done and !burst_q |=> st_q == HPP_CTRL)
        else $error("single access did not return to control");
    AST_CS_END: assert property (sel_q && csn_s |=> st_q == HPP_IDLE && bcnt_q == 4'h0)
        else $error("deselect did not end access");

endmodule : hpp_host_port
`default_nettype wire

//--- hw/hpp_map.svh
/*
 * Constants of the host processor port: pin widths, strap bit positions
 * and serial control word layout.
 * Assumes inclusion by bare name from the package and the port module.
 */
`ifndef HPP_MAP_SVH
`define HPP_MAP_SVH

`define HPP_ADDR_BITS 13
`define HPP_DATA_BITS 8
// Strap positions on the data bus in serial mode
`define HPP_STRAP_CPOL 7
`define HPP_STRAP_CPHA 6
`define HPP_STRAP_SWAP 5
// Serial control word: two bytes, direction first, burst flag last
`define HPP_CTRL_LAST 4'hF
`define HPP_DATA_LAST 4'h7
`define HPP_CW_RW 15
`define HPP_CW_BURST 0

`endif

//--- hw/hpp_pkg.sv
/*
 * Types of the host processor port: synchronised pin bundle and the
 * serial slave state encoding.
 * Assumes hpp_map.svh on the include path.
 */
`include "hpp_map.svh"

package hpp_pkg;

    typedef logic [`HPP_ADDR_BITS-1:0] hpp_addr_t;
    typedef logic [`HPP_DATA_BITS-1:0] hpp_data_t;

    typedef struct packed {
        logic serial_sel;
        logic bus_style;
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic ds_n;
        logic rw;
        logic sclk;
        logic mosi;
        hpp_addr_t addr;
        hpp_data_t data;
    } hpp_pins_s;

    typedef enum logic [1:0] {
        HPP_IDLE = 2'b00,
        HPP_CTRL = 2'b01,
        HPP_DATA = 2'b10
    } hpp_state_e;

endpackage : hpp_pkg

//--- verif/hpp_host_model.sv
/*
 * Host processor model: parallel cycles in both strobe styles and serial master frames.
 * Assumes the bench resolves the shared data bus and the serial data wire.
 */
`timescale 1ns/1ps
`default_nettype none
module hpp_host_model (
    input wire logic mclk,
    input wire hpp_pkg::hpp_data_t bus,
    input wire logic miso,
    output var logic spi_sel,
    output var logic style,
    output var logic cs_n,
    output var logic rd_n,
    output var logic wr_n,
    output var logic ds_n,
    output var logic rw,
    output var hpp_pkg::hpp_addr_t adr,
    output var hpp_pkg::hpp_data_t dq,
    output var logic dq_oe,
    output var logic sclk,
    output var logic mosi
);
    import hpp_pkg::*;
    logic cpol = 1'b0;
    logic cpha = 1'b0;
    logic swap = 1'b0;
    initial begin
        {spi_sel, style, cs_n, rd_n, wr_n, ds_n, rw, sclk, mosi, dq_oe} = 10'h0F8;
        {adr, dq} = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Straps are driven on the data bus while chip select is high
    task automatic mode(input logic sel, input logic [2:0] m);
        @(posedge mclk);
        {spi_sel, style, cpol, cpha, swap, sclk, dq_oe} <= {sel, m[0], m, m[2], sel};
        dq <= {m, 5'h00};
        repeat (8) @(posedge mclk);
    endtask : mode
    task automatic par(input logic cs, input logic wr, input hpp_addr_t a,
            input hpp_data_t wd, output hpp_data_t rd);
        @(posedge mclk);
        {cs_n, adr, dq, dq_oe, rw} <= {cs, a, wd, wr, !wr};
        @(posedge mclk);
        if (style) ds_n <= 1'b0;
        else if (wr) wr_n <= 1'b0;
        else rd_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rd = bus;
        {cs_n, rd_n, wr_n, ds_n, dq_oe} <= 5'h1E;
        repeat (6) @(posedge mclk);
    endtask : par
    ////////////////////////////////////////////////////////////////////////////////
    // Serial clock only moves inside a frame; slow, bulk data goes parallel
    function automatic hpp_data_t ord(input hpp_data_t d);
        hpp_data_t v;
        v = d;
        if (swap) v = {<<{d}};
        return v;
    endfunction : ord
    task automatic sbit(input logic t, output logic r);
        if (!cpha) mosi <= t;
        repeat (16) @(posedge mclk);
        sclk <= !cpol;
        if (cpha) mosi <= t;
        else r = miso;
        repeat (16) @(posedge mclk);
        sclk <= cpol;
        if (cpha) r = miso;
    endtask : sbit
    task automatic sbyte(input hpp_data_t t, output hpp_data_t r);
        for (int i = 7; i >= 0; i--) sbit(t[i], r[i]);
    endtask : sbyte
    task automatic sctl(input logic rd, input logic burst, input hpp_addr_t a);
        logic [13:0] mid;
        logic [15:0] cw;
        hpp_data_t r;
        mid = {1'b0, a};
        if (swap) mid = {<<{{1'b0, a}}};
        cw = {rd, mid, burst};
        sbyte(cw[15:8], r);
        sbyte(cw[7:0], r);
    endtask : sctl
    task automatic sopen();
        @(posedge mclk);
        cs_n <= 1'b0;
        repeat (16) @(posedge mclk);
    endtask : sopen
    task automatic sclose();
        repeat (16) @(posedge mclk);
        cs_n <= 1'b1;
        repeat (16) @(posedge mclk);
    endtask : sclose
endmodule : hpp_host_model
`default_nettype wire

//--- verif/hpp_host_port_bench.sv
/*
 * Testbench of the host processor port: both strobe styles, all serial modes, bursts,
 * chip-select gating and the interrupt pin.
 * Assumes hpp_host_model as host and a one-cycle register core modelled here.
 */
`timescale 1ns/1ps
`default_nettype none
module hpp_host_port_bench;
    import hpp_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic irq_pending = 1'b0;
    logic flt = 1'b0;
    logic spi_sel, style, cs_n, rd_n, wr_n, ds_n, rw, sclk, mosi, dq_oe, data_oe, reg_wr, reg_rd;
    logic serial_miso, serial_miso_oe, interrupt_request_n, interrupt_request_oe, miso_w, irq_w;
    hpp_addr_t adr, reg_addr, last_wa;
    hpp_data_t dq, bus, data_out, reg_wdata, last_wd;
    hpp_data_t reg_rdata = '0;
    hpp_data_t mem [8192];
    int fails = 0;
    int checks_done = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;
    // Released bus and miso lines show a changing pattern, not a stale value; the released interrupt line reads high
    assign bus = data_oe ? data_out : (dq_oe ? dq : ({8{flt}} ^ 8'hA5));
    assign miso_w = serial_miso_oe ? serial_miso : flt;
    assign irq_w = interrupt_request_oe ? interrupt_request_n : 1'b1;
    always #2.5 mclk = !mclk;
    always @(posedge mclk) begin
        flt <= !flt;
        if (reg_rd === 1'b1) begin
            reg_rdata <= mem[reg_addr];
            rd_cnt++;
        end
        if (reg_wr === 1'b1) begin
            mem[reg_addr] = reg_wdata;
            {last_wa, last_wd} = {reg_addr, reg_wdata};
            wr_cnt++;
        end
    end
    hpp_host_model hpp_host_model_inst (.mclk, .bus, .miso(miso_w), .spi_sel, .style, .cs_n,
        .rd_n, .wr_n, .ds_n, .rw, .adr, .dq, .dq_oe, .sclk, .mosi);
    hpp_host_port hpp_host_port_inst (.mclk, .resetn, .serial_port_select(spi_sel),
        .bus_style_select(style), .chip_select_n(cs_n), .address(adr), .data_in(bus),
        .data_out, .data_oe, .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .read_write_select(rw), .data_strobe_n(ds_n), .serial_clock(sclk),
        .serial_mosi(mosi), .serial_miso, .serial_miso_oe, .irq_pending,
        .interrupt_request_n, .interrupt_request_oe, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_par();
        hpp_data_t r;
        int w;
        for (int s = 0; s < 2; s++) begin
            hpp_host_model_inst.mode(1'b0, 3'(s));
            w = wr_cnt + rd_cnt;
            hpp_host_model_inst.par(1'b1, 1'b1, 13'h0005, 8'h11, r);
            hpp_host_model_inst.par(1'b1, 1'b0, 13'h0005, 8'h11, r);
            chk(16'(wr_cnt + rd_cnt - w), 16'h0000);
            hpp_host_model_inst.par(1'b0, 1'b1, 13'h1ABC, 8'h3C ^ 8'(s), r);
            chk({3'h0, last_wa}, 16'h1ABC);
            chk(16'(last_wd), 16'(8'h3C ^ 8'(s)));
            hpp_host_model_inst.par(1'b0, 1'b0, 13'h1ABC, 8'h00, r);
            chk(16'(r), 16'(8'h3C ^ 8'(s)));
            hpp_host_model_inst.par(1'b0, 1'b0, 13'h1F33, 8'h00, r);
            chk(16'(r), 16'h0069);
        end
    endtask : t_par
    task automatic t_spi();
        hpp_data_t r;
        hpp_addr_t a;
        for (int m = 0; m < 8; m++) begin
            a = 13'h0A53 + 13'(m * 257);
            hpp_host_model_inst.mode(1'b1, 3'(m));
            hpp_host_model_inst.sopen();
            hpp_host_model_inst.sctl(1'b0, 1'b0, a);
            hpp_host_model_inst.sbyte(hpp_host_model_inst.ord(8'hC3 ^ 8'(m)), r);
            hpp_host_model_inst.sctl(1'b1, 1'b0, a);
            hpp_host_model_inst.sbyte(8'h00, r);
            hpp_host_model_inst.sclose();
            chk({3'h0, last_wa}, 16'(a));
            chk(16'(last_wd), 16'(8'hC3 ^ 8'(m)));
            chk(16'(hpp_host_model_inst.ord(r)), 16'(8'hC3 ^ 8'(m)));
        end
    endtask : t_spi
    task automatic t_burst();
        hpp_data_t r;
        int w;
        hpp_host_model_inst.mode(1'b1, 3'b000);
        w = wr_cnt;
        hpp_host_model_inst.sopen();
        hpp_host_model_inst.sctl(1'b0, 1'b1, 13'h1FFD);
        for (int i = 0; i < 3; i++) hpp_host_model_inst.sbyte(8'h70 + 8'(i), r);
        hpp_host_model_inst.sclose();
        chk(16'(wr_cnt - w), 16'h0003);
        chk({3'h0, last_wa}, 16'h1FFF);
        hpp_host_model_inst.sopen();
        hpp_host_model_inst.sctl(1'b1, 1'b1, 13'h1FFD);
        for (int i = 0; i < 3; i++) begin
            hpp_host_model_inst.sbyte(8'h00, r);
            chk(16'(r), 16'(8'h70 + 8'(i)));
        end
        hpp_host_model_inst.sclose();
        hpp_host_model_inst.sopen();
        hpp_host_model_inst.sctl(1'b1, 1'b0, 13'h1FFE);
        hpp_host_model_inst.sbyte(8'h00, r);
        hpp_host_model_inst.sclose();
        chk(16'(r), 16'h0071);
    endtask : t_burst
    task automatic t_irq();
        irq_pending <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(16'(irq_w), 16'h0000);
        irq_pending <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(16'(irq_w), 16'h0001);
    endtask : t_irq
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'h5A;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(16'({data_oe, serial_miso_oe, interrupt_request_oe}), 16'h0000);
        t_par();
        t_spi();
        t_burst();
        t_irq();
        conclude();
    end
    initial begin
        repeat (90000) @(posedge mclk);
        fails++;
        conclude();
    end
endmodule : hpp_host_port_bench
`default_nettype wire
